// ==== design/filt_regs.vh ====
`ifndef FILT_REGS_VH
`define FILT_REGS_VH

// ----------------------------------------------------------------
// Per-channel register offsets (word index, channel in address 8:6)
// ----------------------------------------------------------------
`define R_CTRL       6'h00
`define R_FIR_FC     6'h01
`define R_IIR_FLO    6'h02
`define R_IIR_FHI    6'h03
`define R_STAT       6'h04
`define R_FIR_C0     6'h10
`define R_IIR_C0     6'h20

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_FIR_EN  0
`define CTRL_IIR_EN  1
`define CTRL_ORD_LO  4
`define CTRL_ORD_HI  7
`define CTRL_TYP_LO  8
`define CTRL_TYP_HI  9
`define CTRL_RST     10'h0E0
`define TYPE_LP      2'h0
`define TYPE_HP      2'h1
`define TYPE_BP      2'h2
`define TYPE_BS      2'h3
`define STAT_FIR_ERR 0
`define STAT_IIR_ERR 1
`define FC_RST       16'h0000

// ----------------------------------------------------------------
// Coefficients: signed Q2.14, unity is the reset tap
// ----------------------------------------------------------------
`define COEF_FRAC    14
`define COEF_UNITY   16'h4000

// ----------------------------------------------------------------
// Corner limits as a fraction of sample_rate, 16'h10000 = 1.0
// ----------------------------------------------------------------
`define FIR14_MIN    16'h0CCD
`define FIR14_MAX    16'h30A3
`define FIR12_MIN    16'h0F5D
`define FIR12_MAX    16'h3999
`define FIR10_MIN    16'h11EC
`define FIR10_MAX    16'h451E
`define FIR8_MIN     16'h170B
`define FIR8_MAX     16'h570A
`define FIR6_MIN     16'h1EB9
`define FIR6_MAX     16'h5999
`define FIR4_MIN     16'h2E15
`define FIR4_MAX     16'h68F5
`define IIR_FC_MAX   16'h7D70

`endif

// ==== design/filter_chain.v ====
`timescale 1ns/1ns
`default_nettype none
`include "filt_regs.vh"

module filter_chain #(
  parameter DW         = 16,
  parameter FIFO_DEPTH = 4
) (
  input  wire          core_clk_i,
  input  wire          rstn_i,
  input  wire          ce_i,
  input  wire [9:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  output reg  [31:0]   avs_readdata_o,
  output reg           avs_waitrequest_o,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [2:0]    in_chan_i,
  input  wire [DW-1:0] in_data_i,
  output reg           out_valid_o,
  input  wire          out_ready_i,
  output reg  [2:0]    out_chan_o,
  output reg  [DW-1:0] out_data_o
);

  localparam NCH  = 8;
  localparam TAPS = 15;
  localparam NIC  = 10;
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_FIR  = 4'b0010;
  localparam [3:0] S_IIR  = 4'b0100;
  localparam [3:0] S_OUT  = 4'b1000;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function fir_ok;
    input [3:0]  n;
    input [15:0] fc;
    begin
      case (n)
        4'hE:    fir_ok = fc >= `FIR14_MIN && fc <= `FIR14_MAX;
        4'hC:    fir_ok = fc >= `FIR12_MIN && fc <= `FIR12_MAX;
        4'hA:    fir_ok = fc >= `FIR10_MIN && fc <= `FIR10_MAX;
        4'h8:    fir_ok = fc >= `FIR8_MIN && fc <= `FIR8_MAX;
        4'h6:    fir_ok = fc >= `FIR6_MIN && fc <= `FIR6_MAX;
        4'h4:    fir_ok = fc >= `FIR4_MIN && fc <= `FIR4_MAX;
        default: fir_ok = 1'b0;
      endcase
    end
  endfunction

  function iir_ok;
    input [1:0]  t;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (t == `TYPE_LP || t == `TYPE_HP)
        iir_ok = lo != 16'h0000 && lo <= `IIR_FC_MAX;
      else
        iir_ok = lo != 16'h0000 && lo < hi && hi <= `IIR_FC_MAX;
    end
  endfunction

  function signed [15:0] sat;
    input signed [39:0] a;
    reg signed [39:0] s;
    begin
      s = a >>> `COEF_FRAC;
      if (s > 40'sh0000007FFF)
        sat = 16'sh7FFF;
      else if (s < 40'shFFFFFF8000)
        sat = 16'sh8000;
      else
        sat = s[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg        [9:0]  ctrl_r   [0:NCH-1];
  reg        [15:0] fir_fc_r [0:NCH-1];
  reg        [15:0] iir_lo_r [0:NCH-1];
  reg        [15:0] iir_hi_r [0:NCH-1];
  reg signed [15:0] fir_c_r  [0:NCH*TAPS-1];
  reg signed [15:0] iir_c_r  [0:NCH*NIC-1];
  reg signed [15:0] xl_r     [0:NCH*TAPS-1];
  reg signed [15:0] ix1_r    [0:2*NCH-1];
  reg signed [15:0] ix2_r    [0:2*NCH-1];
  reg signed [15:0] iy1_r    [0:2*NCH-1];
  reg signed [15:0] iy2_r    [0:2*NCH-1];

  reg        [3:0]  st_r;
  reg        [2:0]  ch_r;
  reg        [3:0]  k_r;
  reg               stg_r;
  reg signed [39:0] acc_r;
  reg signed [15:0] smp_r;
  reg signed [39:0] acc_nxt;
  reg signed [39:0] bq_nxt;
  reg signed [15:0] bq_y;
  integer           i;
  integer           b;
  integer           sx;

  wire [2:0]        a_ch  = avs_address_i[8:6];
  wire [5:0]        a_reg = avs_address_i[5:0];
  wire              a_hit = ~avs_address_i[9];
  wire              wr_go = ce_i & avs_write_i & ~avs_waitrequest_o & a_hit;
  wire [DW+2:0]     f_data;
  wire              f_valid;
  wire              f_pop = (st_r == S_IDLE) & f_valid;
  wire [9:0]        cur_ctrl = ctrl_r[ch_r];

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  sample_fifo #(
    .W     (DW + 3),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .s_valid_i  (in_valid_i),
    .s_ready_o  (in_ready_o),
    .s_data_i   ({in_chan_i, in_data_i}),
    .m_valid_o  (f_valid),
    .m_ready_i  (f_pop & ce_i),
    .m_data_o   (f_data)
  );

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  // Readdata is loaded on the waited edge so it stands while waitrequest is low
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end
    else if (ce_i)
    begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o)
      begin
        avs_readdata_o <= 32'h00000000;
        if (a_hit)
        begin
          if (a_reg == `R_CTRL)
            avs_readdata_o <= {22'h000000, ctrl_r[a_ch]};
          else if (a_reg == `R_FIR_FC)
            avs_readdata_o <= {16'h0000, fir_fc_r[a_ch]};
          else if (a_reg == `R_IIR_FLO)
            avs_readdata_o <= {16'h0000, iir_lo_r[a_ch]};
          else if (a_reg == `R_IIR_FHI)
            avs_readdata_o <= {16'h0000, iir_hi_r[a_ch]};
          else if (a_reg == `R_STAT)
            avs_readdata_o <= {30'h00000000,
              ~iir_ok(ctrl_r[a_ch][`CTRL_TYP_HI:`CTRL_TYP_LO], iir_lo_r[a_ch], iir_hi_r[a_ch]),
              ~fir_ok(ctrl_r[a_ch][`CTRL_ORD_HI:`CTRL_ORD_LO], fir_fc_r[a_ch])};
          else if (a_reg >= `R_FIR_C0 && a_reg < `R_FIR_C0 + TAPS)
            avs_readdata_o <= {{16{fir_c_r[a_ch*TAPS+a_reg-`R_FIR_C0][15]}},
                               fir_c_r[a_ch*TAPS+a_reg-`R_FIR_C0]};
          else if (a_reg >= `R_IIR_C0 && a_reg < `R_IIR_C0 + NIC)
            avs_readdata_o <= {{16{iir_c_r[a_ch*NIC+a_reg-`R_IIR_C0][15]}},
                               iir_c_r[a_ch*NIC+a_reg-`R_IIR_C0]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers, one set per channel
  // ----------------------------------------------------------------
  // Enable bits live beside the settings, so clearing them leaves the rest alone
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        ctrl_r[i]   <= `CTRL_RST;
        fir_fc_r[i] <= `FC_RST;
        iir_lo_r[i] <= `FC_RST;
        iir_hi_r[i] <= `FC_RST;
      end
      for (i = 0; i < NCH * TAPS; i = i + 1)
        fir_c_r[i] <= (i % TAPS == 0) ? `COEF_UNITY : 16'h0000;
      for (i = 0; i < NCH * NIC; i = i + 1)
        iir_c_r[i] <= (i % 5 == 0) ? `COEF_UNITY : 16'h0000;
    end
    else if (wr_go)
    begin
      if (a_reg == `R_CTRL)
        ctrl_r[a_ch] <= avs_writedata_i[9:0];
      else if (a_reg == `R_FIR_FC)
        fir_fc_r[a_ch] <= avs_writedata_i[15:0];
      else if (a_reg == `R_IIR_FLO)
        iir_lo_r[a_ch] <= avs_writedata_i[15:0];
      else if (a_reg == `R_IIR_FHI)
        iir_hi_r[a_ch] <= avs_writedata_i[15:0];
      else if (a_reg >= `R_FIR_C0 && a_reg < `R_FIR_C0 + TAPS)
        fir_c_r[a_ch*TAPS+a_reg-`R_FIR_C0] <= avs_writedata_i[15:0];
      else if (a_reg >= `R_IIR_C0 && a_reg < `R_IIR_C0 + NIC)
        iir_c_r[a_ch*NIC+a_reg-`R_IIR_C0] <= avs_writedata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic: one FIR tap or one biquad section per cycle
  // ----------------------------------------------------------------
  // One multiplier for the FIR trades latency (N+1 cycles) for area
  always @*
  begin
    sx      = ch_r * TAPS + k_r;
    b       = ch_r * NIC + stg_r * 5;
    acc_nxt = acc_r + fir_c_r[sx] * xl_r[sx];
    bq_nxt  = iir_c_r[b] * smp_r
            + iir_c_r[b+1] * ix1_r[ch_r*2+stg_r]
            + iir_c_r[b+2] * ix2_r[ch_r*2+stg_r]
            - iir_c_r[b+3] * iy1_r[ch_r*2+stg_r]
            - iir_c_r[b+4] * iy2_r[ch_r*2+stg_r];
    bq_y    = sat(bq_nxt);
  end

  // ----------------------------------------------------------------
  // Sample sequencer: FIR, then two biquads, then output
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      st_r        <= S_IDLE;
      ch_r        <= 3'h0;
      k_r         <= 4'h0;
      stg_r       <= 1'b0;
      acc_r       <= 40'sh0000000000;
      smp_r       <= 16'sh0000;
      out_valid_o <= 1'b0;
      out_chan_o  <= 3'h0;
      out_data_o  <= {DW{1'b0}};
      for (i = 0; i < NCH * TAPS; i = i + 1)
        xl_r[i] <= 16'sh0000;
      for (i = 0; i < 2 * NCH; i = i + 1)
      begin
        ix1_r[i] <= 16'sh0000;
        ix2_r[i] <= 16'sh0000;
        iy1_r[i] <= 16'sh0000;
        iy2_r[i] <= 16'sh0000;
      end
    end
    else if (ce_i)
    begin
      if (out_valid_o && out_ready_i)
        out_valid_o <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          if (f_valid)
          begin
            ch_r  <= f_data[DW+2:DW];
            smp_r <= f_data[DW-1:0];
            k_r   <= 4'h0;
            stg_r <= 1'b0;
            acc_r <= 40'sh0000000000;
            if (ctrl_r[f_data[DW+2:DW]][`CTRL_FIR_EN])
            begin
              // Delay line only moves while its FIR is on
              xl_r[f_data[DW+2:DW]*TAPS] <= f_data[DW-1:0];
              for (i = 1; i < TAPS; i = i + 1)
                xl_r[f_data[DW+2:DW]*TAPS+i] <= xl_r[f_data[DW+2:DW]*TAPS+i-1];
              st_r <= S_FIR;
            end
            else
              st_r <= S_IIR;
          end
        end
        S_FIR:
        begin
          acc_r <= acc_nxt;
          k_r   <= k_r + 4'h1;
          if (k_r == cur_ctrl[`CTRL_ORD_HI:`CTRL_ORD_LO] || k_r == TAPS - 1)
          begin
            smp_r <= sat(acc_nxt);
            st_r  <= S_IIR;
          end
        end
        S_IIR:
        begin
          if (cur_ctrl[`CTRL_IIR_EN])
          begin
            ix1_r[ch_r*2+stg_r] <= smp_r;
            ix2_r[ch_r*2+stg_r] <= ix1_r[ch_r*2+stg_r];
            iy1_r[ch_r*2+stg_r] <= bq_y;
            iy2_r[ch_r*2+stg_r] <= iy1_r[ch_r*2+stg_r];
            smp_r <= bq_y;
            stg_r <= 1'b1;
            if (stg_r)
              st_r <= S_OUT;
          end
          else
            st_r <= S_OUT;
        end
        S_OUT:
        begin
          // Hold the result until the previous one has been taken
          if (!out_valid_o || out_ready_i)
          begin
            out_valid_o <= 1'b1;
            out_chan_o  <= ch_r;
            out_data_o  <= smp_r;
            st_r        <= S_IDLE;
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

endmodule // filter_chain

`default_nettype wire

// ==== design/sample_fifo.v ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Small valid/ready FIFO, both flags registered
// ----------------------------------------------------------------
module sample_fifo #(
  parameter W     = 19,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire         core_clk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  input  wire         s_valid_i,
  output reg          s_ready_o,
  input  wire [W-1:0] s_data_i,
  output reg          m_valid_o,
  input  wire         m_ready_i,
  output wire [W-1:0] m_data_o
);

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  reg [AW:0]   cnt_nxt;
  wire         push;
  wire         pop;

  assign push     = s_valid_i & s_ready_o;
  assign pop      = m_valid_o & m_ready_i;
  assign m_data_o = mem_r[rp_r];

  // Occupancy after this edge
  always @*
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  // Flags come from the next count so they never lag a cycle
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wp_r      <= {AW{1'b0}};
      rp_r      <= {AW{1'b0}};
      cnt_r     <= {(AW+1){1'b0}};
      s_ready_o <= 1'b0;
      m_valid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem_r[wp_r] <= s_data_i;
        wp_r        <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      cnt_r     <= cnt_nxt;
      s_ready_o <= (cnt_nxt != DEPTH);
      m_valid_o <= (cnt_nxt != 0);
    end
  end

endmodule // sample_fifo

`default_nettype wire

// ==== tb/filter_chain_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the filter chain
// ----------------------------------------------------------------
module filter_chain_checker #(
  parameter DW = 16
) (
  input wire logic          core_clk_i,
  input wire logic          rstn_i,
  input wire logic          ce_i,
  input wire logic [9:0]    avs_address_i,
  input wire logic          avs_read_i,
  input wire logic          avs_write_i,
  input wire logic [31:0]   avs_readdata_o,
  input wire logic          avs_waitrequest_o,
  input wire logic          in_valid_i,
  input wire logic          in_ready_o,
  input wire logic          out_valid_o,
  input wire logic          out_ready_i,
  input wire logic [2:0]    out_chan_o,
  input wire logic [DW-1:0] out_data_o
);
  logic [3:0] pend_r;
  // Samples accepted but not yet delivered; a delivery needs a source
  always_ff @(posedge core_clk_i)
    if (!rstn_i)
      pend_r <= 4'h0;
    else if (ce_i)
      pend_r <= pend_r + {3'h0, in_valid_i && in_ready_o} - {3'h0, out_valid_o && out_ready_i};

  // Frozen clock enable holds everything, so checking pauses with it
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i || !ce_i);

  a_wait_one_cycle:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered in the next cycle");
  a_wait_low_once:
  assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero:
  assert property (avs_read_i && avs_waitrequest_o && avs_address_i[9] |=> avs_readdata_o == 32'h00000000)
    else $error("read outside the map returned data");
  a_rdata_stands:
  assert property ($changed(avs_readdata_o) |-> $past(avs_read_i) && $past(avs_waitrequest_o))
    else $error("read data changed without a read");
  a_out_hold_stall:
  assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_chan_o))
    else $error("output sample changed while stalled");
  a_out_has_src:
  assert property (out_valid_o |-> pend_r != 4'h0)
    else $error("output sample without an accepted input");
  a_min_latency:
  assert property (in_valid_i && in_ready_o && pend_r == 4'h0 |=> !out_valid_o [*3])
    else $error("output sample earlier than the pipeline allows");
  a_max_latency:
  assert property (in_valid_i && in_ready_o && pend_r == 4'h0 |-> ##[4:22] out_valid_o)
    else $error("output sample late");
endmodule // filter_chain_checker

bind filter_chain filter_chain_checker #(.DW(DW)) u_chk (
  .core_clk_i        (core_clk_i),
  .rstn_i            (rstn_i),
  .ce_i              (ce_i),
  .avs_address_i     (avs_address_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_readdata_o    (avs_readdata_o),
  .avs_waitrequest_o (avs_waitrequest_o),
  .in_valid_i        (in_valid_i),
  .in_ready_o        (in_ready_o),
  .out_valid_o       (out_valid_o),
  .out_ready_i       (out_ready_i),
  .out_chan_o        (out_chan_o),
  .out_data_o        (out_data_o)
);
`default_nettype wire

// ==== tb/stream_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Upstream sample source and downstream sink
// ----------------------------------------------------------------
module stream_partner (
  input wire logic        core_clk_i,
  input wire logic        stall_i,
  input wire logic        in_ready_i,
  input wire logic        out_valid_i,
  input wire logic [2:0]  out_chan_i,
  input wire logic [15:0] out_data_i,
  output var logic        in_valid_o,
  output var logic [2:0]  in_chan_o,
  output var logic [15:0] in_data_o,
  output var logic        out_ready_o
);
  logic [1:0]  cyc_r = 2'h0;
  logic [18:0] got [$];
  initial
  begin
    in_valid_o = 1'b0;
    in_chan_o = 3'h0;
    in_data_o = 16'h0000;
    out_ready_o = 1'b0;
  end
  // Sink refuses one cycle in four, and always while stall_i is high
  always @(posedge core_clk_i)
  begin
    cyc_r <= cyc_r + 2'h1;
    out_ready_o <= !stall_i && cyc_r != 2'h3;
    if (out_valid_i && out_ready_o)
      got.push_back({out_chan_i, out_data_i});
  end
  // Hold the sample until taken; idle data is inverted so no stale value hides
  task send(input logic [2:0] c, input logic [15:0] d);
    @(posedge core_clk_i);
    in_valid_o <= 1'b1;
    in_chan_o <= c;
    in_data_o <= d;
    do @(posedge core_clk_i); while (in_ready_i !== 1'b1);
    in_valid_o <= 1'b0;
    in_data_o <= ~d;
  endtask
endmodule // stream_partner
`default_nettype wire

// ==== tb/test_per_channel_fir_iir_filter_chain.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_per_channel_fir_iir_filter_chain;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        stall = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] readdata, q;
  logic        waitreq, in_valid, in_ready, out_valid, out_ready;
  logic [2:0]  in_chan, out_chan;
  logic [15:0] in_data, out_data;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n;
  // Rows: op (1 write, 0 read+compare), address, data
  logic [47:0] rows [0:60] = '{
    48'h0_000_000000E0, 48'h0_001_00000000, 48'h0_004_00000003, 48'h0_010_00004000, 48'h0_011_00000000,
    48'h0_020_00004000, 48'h0_021_00000000, 48'h1_040_000000E0, 48'h1_041_00000CCC, 48'h0_044_00000003,
    48'h1_041_00000CCD, 48'h0_044_00000002, 48'h1_041_000030A3, 48'h0_044_00000002, 48'h1_041_000030A4,
    48'h0_044_00000003, 48'h1_040_00000240, 48'h1_041_00002E15, 48'h1_042_00001000, 48'h1_043_00001000,
    48'h0_044_00000002, 48'h1_043_00001001, 48'h0_044_00000000, 48'h1_043_00007D71, 48'h0_044_00000002,
    48'h1_043_00007D70, 48'h0_044_00000000, 48'h1_041_00002E14, 48'h0_044_00000001, 48'h1_043_00000000,
    48'h0_044_00000003, 48'h1_040_00000040, 48'h0_044_00000001, 48'h1_042_00007D71, 48'h0_044_00000003,
    48'h0_040_00000040, 48'h1_044_FFFFFFFF, 48'h0_044_00000003, 48'h0_080_000000E0, 48'h1_200_00001234,
    48'h0_200_00000000, 48'h1_045_0000FFFF, 48'h0_045_00000000, 48'h1_0C0_FFFFFFFF, 48'h0_0C0_000003FF,
    48'h1_100_000000C0, 48'h1_101_00000F5D, 48'h0_104_00000002, 48'h1_100_000000A0, 48'h0_104_00000003,
    48'h1_101_0000451E, 48'h0_104_00000002, 48'h1_101_00005999, 48'h1_100_00000080, 48'h0_104_00000003,
    48'h1_100_00000060, 48'h0_104_00000002, 48'h1_100_00000050, 48'h0_104_00000003, 48'h0_101_00005999,
    48'h0_000_000000E0};
  // Order 4 taps summing to unity, and the step response they give
  logic [15:0] taps [0:4] = '{16'h1000, 16'h1000, 16'h0800, 16'h0800, 16'h1000};
  logic [15:0] step [0:5] = '{16'h0040, 16'h0080, 16'h00A0, 16'h00C0, 16'h0100, 16'h0100};

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial
  forever #10 core_clk = ~core_clk;

  filter_chain #(.DW(16), .FIFO_DEPTH(4)) dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .ce_i(ce), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_chan_i(in_chan), .in_data_i(in_data),
    .out_valid_o(out_valid), .out_ready_i(out_ready), .out_chan_o(out_chan), .out_data_o(out_data));

  stream_partner src (
    .core_clk_i(core_clk), .stall_i(stall), .in_ready_i(in_ready), .out_valid_i(out_valid),
    .out_chan_i(out_chan), .out_data_i(out_data), .in_valid_o(in_valid), .in_chan_o(in_chan),
    .in_data_o(in_data), .out_ready_o(out_ready));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Avalon access; no fixed wait is assumed, the watchdog bounds it
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge core_clk); while (waitreq !== 1'b0);
    r = readdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task expect_out(input logic [2:0] c, input logic [15:0] d);
    int k;
    k = 0;
    while (src.got.size() == 0 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    chk("output sample", {13'h0, c, d}, (src.got.size() != 0) ? {13'h0, src.got.pop_front()} : 32'hFFFFFFFF);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    chk("waitrequest in reset", 32'h1, {31'h0, waitreq});
    chk("in_ready in reset", 32'h0, {31'h0, in_ready});
    chk("out_valid in reset", 32'h0, {31'h0, out_valid});
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 61; i++)
    begin
      bus(rows[i][44], rows[i][41:32], rows[i][31:0], q);
      if (!rows[i][44])
        chk("register read", rows[i][31:0], q);
    end
    // Step through order 4 FIR on channel 0
    bus(1'b1, 10'h000, 32'h00000041, q);
    for (int t = 0; t < 5; t++)
      bus(1'b1, 10'h010 + 10'(t), {16'h0000, taps[t]}, q);
    for (int k = 0; k < 6; k++)
    begin
      src.send(3'h0, 16'h0100);
      expect_out(3'h0, step[k]);
    end
    // Half-gain IIR after the FIR, every type
    bus(1'b1, 10'h020, 32'h00002000, q);
    for (int t = 0; t < 4; t++)
    begin
      bus(1'b1, 10'h000, {22'h0, t[1:0], 8'h43}, q);
      src.send(3'h0, 16'h0100);
      expect_out(3'h0, 16'h0080);
    end
    // Off stages pass through and keep their state
    bus(1'b1, 10'h000, 32'h00000040, q);
    src.send(3'h0, 16'h0300);
    expect_out(3'h0, 16'h0300);
    bus(1'b0, 10'h010, 32'h00000000, q);
    chk("tap kept", 32'h00001000, q);
    bus(1'b1, 10'h000, 32'h00000041, q);
    src.send(3'h0, 16'h0100);
    expect_out(3'h0, 16'h0100);
    // Fill the buffer against a stalled sink, then drain it
    stall <= 1'b1;
    n = 0;
    #1;
    while (in_ready === 1'b1 && n < 12)
    begin
      src.send(3'h5, 16'h8000 + 16'(n));
      n++;
      @(posedge core_clk);
      #1;
    end
    chk("buffer refuses", 32'h1, {31'h0, n >= 4 && in_ready === 1'b0});
    @(posedge core_clk);
    stall <= 1'b0;
    for (int k = 0; k < n; k++)
      expect_out(3'h5, 16'h8000 + 16'(k));
    repeat (4) @(posedge core_clk);
    #1;
    chk("buffer empty again", 32'h1, {31'h0, in_ready});
    // Frozen clock enable holds a read until the enable comes back
    @(posedge core_clk);
    ce <= 1'b0;
    fork
      bus(1'b0, 10'h040, 32'h00000000, q);
      begin
        repeat (6) @(posedge core_clk);
        chk("frozen waitrequest", 32'h1, {31'h0, waitreq});
        chk("frozen read data", 32'h00001000, readdata);
        ce <= 1'b1;
      end
    join
    chk("read after freeze", 32'h00000040, q);
    // Mid-run reset restores the power-on settings
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    bus(1'b0, 10'h040, 32'h00000000, q);
    chk("control after reset", 32'h000000E0, q);
    complete_run;
  end

  // Whole run is under a thousand cycles; this bound only catches a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    complete_run;
  end
endmodule // test_per_channel_fir_iir_filter_chain
`default_nettype wire
